// [pkg/mul_psr_pkg.sv]
////////////////////////////////////////////////////////////////
// Shared constants of the multiply and status-word unit
////////////////////////////////////////////////////////////////
`default_nettype none
package mul_psr_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_OPA     = 8'h04;
    localparam logic [7:0] ADDR_OPB     = 8'h08;
    localparam logic [7:0] ADDR_ACC_LO  = 8'h0c;
    localparam logic [7:0] ADDR_ACC_HI  = 8'h10;
    localparam logic [7:0] ADDR_RES_LO  = 8'h14;
    localparam logic [7:0] ADDR_RES_HI  = 8'h18;
    localparam logic [7:0] ADDR_CUR     = 8'h1c;
    localparam logic [7:0] ADDR_SAVED   = 8'h20;
    localparam logic [7:0] ADDR_STATUS  = 8'h24;
    // Operation codes in the control word
    localparam logic [3:0] OP_CUR_TO_REG    = 4'h0;
    localparam logic [3:0] OP_SAVED_TO_REG  = 4'h1;
    localparam logic [3:0] OP_CUR_WHOLE     = 4'h2;
    localparam logic [3:0] OP_CUR_FLAGS     = 4'h3;
    localparam logic [3:0] OP_SAVED_WHOLE   = 4'h4;
    localparam logic [3:0] OP_SAVED_FLAGS   = 4'h5;
    localparam logic [3:0] OP_CUR_FLAGS_IMM = 4'h6;
    localparam logic [3:0] OP_SAV_FLAGS_IMM = 4'h7;
    localparam logic [3:0] OP_MUL_SHORT     = 4'h8;
    localparam logic [3:0] OP_MLA_SHORT     = 4'h9;
    localparam logic [3:0] OP_UNSIGNED_MULTIPLY_LONG         = 4'ha;
    localparam logic [3:0] OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG         = 4'hb;
    localparam logic [3:0] OP_SIGNED_MULTIPLY_LONG         = 4'hc;
    localparam logic [3:0] OP_SIGNED_MULTIPLY_ACCUMULATE_LONG         = 4'hd;
    // Control word fields
    localparam int CTRL_OP_MSB   = 3;
    localparam int CTRL_SETF_BIT = 4;
    localparam int CTRL_COND_BIT = 5;
    localparam int CTRL_PRIV_BIT = 6;
    // Status word flag positions
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;
    localparam int RES_TOP = 63;
    // Early-termination boundaries of the multiplier
    localparam int M1_LSB = 8;
    localparam int M2_LSB = 16;
    localparam int M3_LSB = 24;
    localparam int WORD_TOP = 31;
    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CYC_LSB  = 8;
    localparam int STAT_CYC_MSB  = 11;
    // Reset values of the status words
    localparam logic [31:0] CUR_RESET   = 32'h0000_0000;
    localparam logic [31:0] SAVED_RESET = 32'h0000_0000;
endpackage : mul_psr_pkg
`default_nettype wire

// [logic/booth_byte_step.sv]
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////
// One pass of the 8-bit multiplier array
////////////////////////////////////////////////////////////////
module booth_byte_step (
    input  wire logic [63:0] mcand_i,        // Extended multiplicand
    input  wire logic [7:0]  digit_i,        // Multiplier byte
    input  wire logic        digit_signed_i, // Byte taken as signed
    input  wire logic [1:0]  step_i,         // Byte position
    input  wire logic [63:0] acc_i,          // Running sum
    output logic      [63:0] acc_o           // Sum after this pass
);
    logic signed [8:0] digit_ext; // Digit with sign or zero
    logic        [63:0] prod;     // Partial product
    logic        [63:0] shifted;  // Partial product in place

    // Partial product of one byte, weighted by position
    always_comb begin
        digit_ext = $signed({digit_signed_i & digit_i[7], digit_i});
        prod      = 64'($signed(mcand_i) * digit_ext); // RULE19
        shifted   = prod << {step_i, 3'b000};
        acc_o     = acc_i + shifted;
    end
endmodule : booth_byte_step
`default_nettype wire

// [logic/mul_psr_unit.sv]
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1 - Status transfers take exactly one cycle
// RULE2 - Register flag write copies bits 31:28
// RULE3 - Immediate flag write copies top four bits
// RULE4 - User whole write changes flags; read whole
// RULE5 - Privileged: saved word flag write, read
// RULE6 - Multiply runs only when condition passes
// RULE7 - Plain multiply ignores accumulate; accumulate adds
// RULE8 - Short multiply keeps low 32 bits only
// RULE9 - Short flags: N bit 31, Z zero
// RULE10 - Flags change only with set-flags bit
// RULE11 - Short: 1 plus m, accumulate m+1
// RULE12 - Short m from uniform upper multiplier bits
// RULE13 - Long multiply writes low and high halves
// RULE14 - Long accumulate adds high:low pair
// RULE15 - Unsigned or two's-complement long variants
// RULE16 - Long flags: N bit 63, Z all
// RULE17 - Long: m+1, long accumulate m+2
// RULE18 - Long m: uniform bits, zero if unsigned
// RULE19 - Eight multiplier bits per array cycle
// RULE20 - Issuer avoids destination equal first operand
// RULE21 - Long registers must be all distinct
// RULE22 - User protects control bits; privileged whole
// RULE23 - Short test tops out at bit 31
module mul_psr_unit (
    input  wire logic        clk_i,  // Core clock
    input  wire logic        rst_i,  // Synchronous reset
    input  wire logic [7:0]  adr_i,  // Byte address
    input  wire logic [31:0] dat_i,  // Write data
    input  wire logic [3:0]  sel_i,  // Byte lanes
    input  wire logic        we_i,   // Write strobe
    input  wire logic        stb_i,  // Strobe
    input  wire logic        cyc_i,  // Cycle
    output logic      [31:0] dat_o,  // Read data
    output logic             ack_o,  // Acknowledge
    output logic             busy_o  // Operation running
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARRAY = 4'b0010,
        ST_ADD   = 4'b0100,
        ST_DONE  = 4'b1000
    } state_t;

    state_t      state_q;     // Engine state
    logic        ack_q;       // Bus answer
    logic [31:0] dat_q;       // Read data flop
    logic [6:0]  ctrl_q;      // Latched control word
    logic [31:0] opa_q;       // First operand
    logic [31:0] opb_q;       // Multiplier operand
    logic [31:0] acc_lo_q;    // Accumulate or low dest
    logic [31:0] acc_hi_q;    // High dest input
    logic [31:0] res_lo_q;    // Low result
    logic [31:0] res_hi_q;    // High result
    logic [31:0] cur_q;       // Current status word
    logic [31:0] saved_q;     // Saved status word
    logic [63:0] mcand_q;     // Extended multiplicand
    logic [31:0] mult_q;      // Latched multiplier
    logic [63:0] sum_q;       // Running product
    logic [63:0] sum_d;       // Product after one pass
    logic [2:0]  m_q;         // Array passes needed
    logic [1:0]  step_q;      // Current byte
    logic [1:0]  extra_q;     // Long and accumulate cycles left
    logic [3:0]  cnt_q;       // Cycles of running op
    logic [3:0]  last_cnt_q;  // Cycles of last op
    logic        wr_en;       // Bus write takes effect
    logic        start;       // Control write accepted
    logic [3:0]  op;          // Opcode being written
    logic [3:0]  lop;         // Latched opcode
    logic        priv;        // Privileged mode
    logic        is_mul_new;  // New op is a multiply
    logic        is_long_new; // New op is long
    logic        is_acc_new;  // New op accumulates
    logic        uns_new;     // New op is unsigned long
    logic        is_long;     // Latched op is long
    logic        is_mul;      // Latched op is a multiply
    logic        last_digit;  // Final pass, not unsigned long
    logic [31:0] flag_wr;     // Source with new flags

    ////////////////////////////////////////////////////////////
    // Helper functions
    ////////////////////////////////////////////////////////////

    // Merge write data into a word by byte lanes
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Replace only the four condition flags
    function automatic logic [31:0] flags_only(
        input logic [31:0] old_v,
        input logic [31:0] src
    );
        logic [31:0] r;
        r = old_v;
        r[mul_psr_pkg::FLAG_N:mul_psr_pkg::FLAG_V] =
            src[mul_psr_pkg::FLAG_N:mul_psr_pkg::FLAG_V]; // RULE2 RULE3
        return r;
    endfunction : flags_only

    // Array passes from upper multiplier bits
    function automatic logic [2:0] array_cycles(
        input logic [31:0] b,
        input logic        ones_ok
    );
        logic [2:0] r;
        // Top of the test is bit 31
        if (b[mul_psr_pkg::WORD_TOP:mul_psr_pkg::M1_LSB] == '0 ||
            (ones_ok &&
             &b[mul_psr_pkg::WORD_TOP:mul_psr_pkg::M1_LSB])) begin
            r = 3'h1; // RULE12 RULE18 RULE23
        end else if (
            b[mul_psr_pkg::WORD_TOP:mul_psr_pkg::M2_LSB] == '0 ||
            (ones_ok &&
             &b[mul_psr_pkg::WORD_TOP:mul_psr_pkg::M2_LSB])) begin
            r = 3'h2; // RULE12 RULE18
        end else if (
            b[mul_psr_pkg::WORD_TOP:mul_psr_pkg::M3_LSB] == '0 ||
            (ones_ok &&
             &b[mul_psr_pkg::WORD_TOP:mul_psr_pkg::M3_LSB])) begin
            r = 3'h3; // RULE12 RULE18
        end else begin
            r = 3'h4;
        end
        return r;
    endfunction : array_cycles

    ////////////////////////////////////////////////////////////
    // Decode
    ////////////////////////////////////////////////////////////

    // Write side of the bus and opcode classes
    always_comb begin
        wr_en = cyc_i & stb_i & we_i & ack_q;
        op    = dat_i[mul_psr_pkg::CTRL_OP_MSB:0];
        start = wr_en & sel_i[0] & (state_q == ST_IDLE) &
                (adr_i == mul_psr_pkg::ADDR_CTRL);
        is_mul_new  = op >= mul_psr_pkg::OP_MUL_SHORT &&
                      op <= mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG;
        is_long_new = op >= mul_psr_pkg::OP_UNSIGNED_MULTIPLY_LONG &&
                      op <= mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG;
        is_acc_new  = op == mul_psr_pkg::OP_MLA_SHORT ||
                      op == mul_psr_pkg::OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG ||
                      op == mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG;
        uns_new     = op == mul_psr_pkg::OP_UNSIGNED_MULTIPLY_LONG ||
                      op == mul_psr_pkg::OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG;
        lop     = ctrl_q[mul_psr_pkg::CTRL_OP_MSB:0];
        priv    = ctrl_q[mul_psr_pkg::CTRL_PRIV_BIT];
        // Codes above the last multiply do nothing
        is_long = lop >= mul_psr_pkg::OP_UNSIGNED_MULTIPLY_LONG &&
                  lop <= mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG;
        is_mul  = lop >= mul_psr_pkg::OP_MUL_SHORT &&
                  lop <= mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG;
        // Unsigned long keeps every byte unsigned
        last_digit = ({1'b0, step_q} == m_q - 3'h1) &&
                     lop != mul_psr_pkg::OP_UNSIGNED_MULTIPLY_LONG &&
                     lop != mul_psr_pkg::OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG; // RULE15
        flag_wr = opa_q;
    end

    ////////////////////////////////////////////////////////////
    // Multiplier array pass
    ////////////////////////////////////////////////////////////

    booth_byte_step u_step (
        .mcand_i        (mcand_q),
        .digit_i        (mult_q[{step_q, 3'b000} +: 8]), // RULE19
        .digit_signed_i (last_digit),
        .step_i         (step_q),
        .acc_i          (sum_q),
        .acc_o          (sum_d)
    );

    ////////////////////////////////////////////////////////////
    // Engine sequencing
    ////////////////////////////////////////////////////////////

    // State flow and pass counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            step_q  <= 2'h0;
            extra_q <= 2'h0;
            m_q     <= 3'h1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        step_q  <= 2'h0;
                        m_q     <= array_cycles(opb_q, !uns_new);
                        // Long adds one cycle, accumulate one more
                        extra_q <= 2'({1'b0, is_long_new} +
                                      {1'b0, is_acc_new}); // RULE11 RULE17
                        // Skipped or status ops finish next cycle
                        if (is_mul_new &&
                            dat_i[mul_psr_pkg::CTRL_COND_BIT]) begin
                            state_q <= ST_ARRAY; // RULE6
                        end else begin
                            state_q <= ST_DONE; // RULE1
                        end
                    end
                end
                ST_ARRAY: begin
                    // One byte per internal cycle
                    if ({1'b0, step_q} == m_q - 3'h1) begin
                        state_q <= (extra_q == 2'h0) ? ST_DONE : ST_ADD;
                    end else begin
                        step_q <= step_q + 2'h1; // RULE19
                    end
                end
                ST_ADD: begin
                    // Spare internal cycles of the long and accumulate forms
                    if (extra_q == 2'h1) begin
                        state_q <= ST_DONE;
                    end
                    extra_q <= extra_q - 2'h1;
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Latch control word and operands at start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q  <= 7'h00;
            mcand_q <= 64'h0;
            mult_q  <= 32'h0;
        end else if (start) begin
            ctrl_q  <= dat_i[6:0];
            mult_q  <= opb_q;
            // Only signed long extends the sign
            if (op == mul_psr_pkg::OP_SIGNED_MULTIPLY_LONG ||
                op == mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG) begin
                mcand_q <= {{32{opa_q[31]}}, opa_q}; // RULE15
            end else begin
                mcand_q <= {32'h0, opa_q};
            end
        end
    end

    // Running sum, seeded with the addend
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sum_q <= 64'h0;
        end else if (start) begin
            if (!is_acc_new) begin
                sum_q <= 64'h0; // RULE7
            end else if (is_long_new) begin
                sum_q <= {acc_hi_q, acc_lo_q}; // RULE14
            end else begin
                sum_q <= {32'h0, acc_lo_q}; // RULE7
            end
        end else if (state_q == ST_ARRAY) begin
            sum_q <= sum_d;
        end
    end

    // Cycle counter of the running operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q      <= 4'h0;
            last_cnt_q <= 4'h0;
        end else if (start) begin
            cnt_q <= 4'h1;
        end else if (state_q == ST_DONE) begin
            last_cnt_q <= cnt_q;
        end else if (state_q != ST_IDLE) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////
    // Results and status words
    ////////////////////////////////////////////////////////////

    // Destination registers at the final cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_lo_q <= 32'h0;
            res_hi_q <= 32'h0;
        end else if (state_q == ST_DONE &&
                     ctrl_q[mul_psr_pkg::CTRL_COND_BIT]) begin
            if (is_mul) begin
                res_lo_q <= sum_q[31:0]; // RULE8 RULE13
                res_hi_q <= is_long ? sum_q[63:32] : 32'h0;
            end else if (lop == mul_psr_pkg::OP_CUR_TO_REG) begin
                res_lo_q <= cur_q; // RULE4
            end else if (lop == mul_psr_pkg::OP_SAVED_TO_REG) begin
                // No saved word exists in user mode
                res_lo_q <= priv ? saved_q : 32'h0; // RULE5
            end
        end
    end

    // Current status word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_q <= mul_psr_pkg::CUR_RESET;
        end else if (state_q == ST_DONE &&
                     ctrl_q[mul_psr_pkg::CTRL_COND_BIT]) begin
            case (lop)
                mul_psr_pkg::OP_CUR_WHOLE: begin
                    // User mode keeps control bits
                    cur_q <= priv ? opa_q :
                             flags_only(cur_q, opa_q); // RULE4 RULE22
                end
                mul_psr_pkg::OP_CUR_FLAGS,
                mul_psr_pkg::OP_CUR_FLAGS_IMM: begin
                    cur_q <= flags_only(cur_q, flag_wr); // RULE2 RULE3
                end
                mul_psr_pkg::OP_MUL_SHORT,
                mul_psr_pkg::OP_MLA_SHORT: begin
                    if (ctrl_q[mul_psr_pkg::CTRL_SETF_BIT]) begin // RULE10
                        cur_q[mul_psr_pkg::FLAG_N] <= sum_q[31]; // RULE9
                        cur_q[mul_psr_pkg::FLAG_Z] <=
                            (sum_q[31:0] == 32'h0); // RULE9
                    end
                end
                mul_psr_pkg::OP_UNSIGNED_MULTIPLY_LONG, mul_psr_pkg::OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG,
                mul_psr_pkg::OP_SIGNED_MULTIPLY_LONG, mul_psr_pkg::OP_SIGNED_MULTIPLY_ACCUMULATE_LONG: begin
                    if (ctrl_q[mul_psr_pkg::CTRL_SETF_BIT]) begin // RULE10
                        cur_q[mul_psr_pkg::FLAG_N] <=
                            sum_q[mul_psr_pkg::RES_TOP]; // RULE16
                        cur_q[mul_psr_pkg::FLAG_Z] <=
                            (sum_q == 64'h0); // RULE16
                    end
                end
                default: begin
                    cur_q <= cur_q;
                end
            endcase
        end else if (wr_en && adr_i == mul_psr_pkg::ADDR_CUR) begin
            cur_q <= lane_merge(cur_q, dat_i, sel_i);
        end
    end

    // Saved status word; ops reach it only when privileged, bus unless a privileged op with its condition set is finishing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            saved_q <= mul_psr_pkg::SAVED_RESET;
        end else if (state_q == ST_DONE && priv &&
                     ctrl_q[mul_psr_pkg::CTRL_COND_BIT]) begin
            if (lop == mul_psr_pkg::OP_SAVED_WHOLE) begin
                saved_q <= opa_q;
            end else if (lop == mul_psr_pkg::OP_SAVED_FLAGS ||
                         lop == mul_psr_pkg::OP_SAV_FLAGS_IMM) begin
                saved_q <= flags_only(saved_q, flag_wr); // RULE5
            end
        end else if (wr_en && adr_i == mul_psr_pkg::ADDR_SAVED) begin
            saved_q <= lane_merge(saved_q, dat_i, sel_i);
        end
    end

    ////////////////////////////////////////////////////////////
    // Bus slave
    ////////////////////////////////////////////////////////////

    // Operand registers written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opa_q    <= 32'h0;
            opb_q    <= 32'h0;
            acc_lo_q <= 32'h0;
            acc_hi_q <= 32'h0;
        end else if (wr_en) begin
            case (adr_i)
                mul_psr_pkg::ADDR_OPA:
                    opa_q <= lane_merge(opa_q, dat_i, sel_i);
                mul_psr_pkg::ADDR_OPB:
                    opb_q <= lane_merge(opb_q, dat_i, sel_i);
                mul_psr_pkg::ADDR_ACC_LO:
                    acc_lo_q <= lane_merge(acc_lo_q, dat_i, sel_i);
                mul_psr_pkg::ADDR_ACC_HI:
                    acc_hi_q <= lane_merge(acc_hi_q, dat_i, sel_i);
                default: begin
                    acc_hi_q <= acc_hi_q;
                end
            endcase
        end
    end

    // Answer one cycle after the request, drop after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    // Read data captured with the answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0;
        end else begin
            case (adr_i)
                mul_psr_pkg::ADDR_CTRL:   dat_q <= {25'h0, ctrl_q};
                mul_psr_pkg::ADDR_OPA:    dat_q <= opa_q;
                mul_psr_pkg::ADDR_OPB:    dat_q <= opb_q;
                mul_psr_pkg::ADDR_ACC_LO: dat_q <= acc_lo_q;
                mul_psr_pkg::ADDR_ACC_HI: dat_q <= acc_hi_q;
                mul_psr_pkg::ADDR_RES_LO: dat_q <= res_lo_q;
                mul_psr_pkg::ADDR_RES_HI: dat_q <= res_hi_q;
                mul_psr_pkg::ADDR_CUR:    dat_q <= cur_q;
                mul_psr_pkg::ADDR_SAVED:  dat_q <= saved_q;
                mul_psr_pkg::ADDR_STATUS: begin
                    dat_q <= 32'h0;
                    dat_q[mul_psr_pkg::STAT_BUSY_BIT] <=
                        (state_q != ST_IDLE);
                    dat_q[mul_psr_pkg::STAT_CYC_MSB:
                          mul_psr_pkg::STAT_CYC_LSB] <= last_cnt_q;
                end
                // Unmapped addresses read zero
                default: dat_q <= 32'h0;
            endcase
        end
    end

    // Output drive
    always_comb begin
        dat_o  = dat_q;
        ack_o  = ack_q;
        busy_o = (state_q != ST_IDLE);
    end
endmodule : mul_psr_unit
`default_nettype wire

// [verif/mul_psr_unit_sva.sv]
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////
module mul_psr_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0]  sel_i,
    input wire logic        we_i,
    input wire logic        stb_i,
    input wire logic        cyc_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Accepted control write while idle
    sequence go_s;
        ack_o && we_i && sel_i[0] && !busy_o && adr_i == 8'h00;
    endsequence
    // Single busy cycle
    sequence one_s;
        busy_o ##1 !busy_o;
    endsequence
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    bus_lat_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    xfer_one_a: assert property (go_s ##0 (!dat_i[3] || !dat_i[5])
        |=> one_s) else $error("one-cycle op wrong length");
    short_len_a: assert property (go_s ##0 dat_i[5]
        && dat_i[3:1] == 3'h4 |=> busy_o[*2] ##[1:5] !busy_o)
        else $error("short multiply length");
    long_len_a: assert property (go_s ##0 dat_i[5]
        && dat_i[3:0] inside {[4'ha:4'hd]} |=> busy_o[*3] ##[1:5] !busy_o)
        else $error("long multiply length");
    busy_max_a: assert property (busy_o[*7] |=> !busy_o)
        else $error("run too long");
    busy_cause_a: assert property ($rose(busy_o)
        |-> $past(ack_o) && $past(we_i) && $past(adr_i) == 8'h00)
        else $error("stray run");
    unmapped_a: assert property (ack_o && !we_i && adr_i > 8'h24
        |-> dat_o == 32'h0) else $error("unmapped read not zero");
endmodule : mul_psr_sva
`default_nettype wire

// [verif/wb_host.sv]
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////
// Issuing side; operands sit in separate registers
module wb_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdat_i,
    output logic             cyc_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      wdat_o
);
    // Idle bus
    initial begin
        cyc_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        wdat_o = 32'h0;
    end
    // One classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        wdat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rdat_i;
        cyc_o <= 1'b0;
        wdat_o <= ~d;
    endtask : xfer
endmodule : wb_host
`default_nettype wire

// [verif/multiply_psr_transfer_unit_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module multiply_psr_transfer_unit_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, we, ack, busy;
    logic [7:0]  adr;
    logic [31:0] wd, rd;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    integer      seed = 62397;
    always #10 clk_i = ~clk_i;
    wb_host host (.clk_i, .ack_i(ack), .rdat_i(rd), .cyc_o(cyc),
        .we_o(we), .adr_o(adr), .wdat_o(wd));
    mul_psr_unit dut (.clk_i, .rst_i, .adr_i(adr), .dat_i(wd),
        .sel_i(4'hf), .we_i(we), .stb_i(cyc), .cyc_i(cyc), .dat_o(rd),
        .ack_o(ack), .busy_o(busy));
    // Verdict and end of run
    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Read one register and compare
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        host.xfer(1'b0, a, 32'h0, v);
        n_tests++;
        if (v !== e) begin
            n_errors++;
            $display("BAD reg %h exp %h got %h", a, e, v);
        end
    endtask : chk
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin : main
        logic [31:0] cur, sav, a, b, lo, hi, v;
        logic [63:0] p, sa, sb;
        logic [3:0]  op;
        logic        pv, sf, cn;
        int          m, n;
        cur = $random(seed);
        sav = $random(seed);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(8'h1c, 32'h0);
        chk(8'h40, 32'h0);
        host.xfer(1'b1, 8'h1c, cur, v);
        host.xfer(1'b1, 8'h20, sav, v);
        for (int i = 0; i < 90; i++) begin
            op = 4'($unsigned($random(seed)) % 14);
            {pv, sf, cn} = 3'($random(seed)) | 3'(i % 9 != 0);
            a = $random(seed);
            b = 32'($signed($random(seed)) >>> (8 * (i % 4)));
            lo = $random(seed);
            hi = $random(seed);
            // Early-termination count from the multiplier
            m = 4;
            for (int k = 3; k >= 1; k--)
                if ((b >> 8 * k) == 0 || (!(op[1] && !op[2]) &&
                    32'($signed(b) >>> 8 * k) == '1)) m = k;
            sa = op[2] ? {{32{a[31]}}, a} : {32'h0, a};
            sb = op[2] ? {{32{b[31]}}, b} : {32'h0, b};
            p = sa * sb + (op[0] ? {hi, lo} : 64'h0);
            if (op[3:1] == 3'h4) p = {32'h0, a * b + (op[0] ? lo : 32'h0)};
            n = op[3] && cn ? m + 1 + (op[1] | op[2]) + op[0] : 1;
            if (cn) case (op)
                0: p[31:0] = cur;
                1: p[31:0] = pv ? sav : 32'h0;
                2: cur = pv ? a : {a[31:28], cur[27:0]};
                3, 6: cur[31:28] = a[31:28];
                4: if (pv) sav = a;
                5, 7: if (pv) sav[31:28] = a[31:28];
                default: if (sf) cur[31:30] = (op[1] | op[2]) ?
                    {p[63], p == 0} : {p[31], p[31:0] == 0};
            endcase
            host.xfer(1'b1, 8'h04, a, v);
            host.xfer(1'b1, 8'h08, b, v);
            host.xfer(1'b1, 8'h0c, lo, v);
            host.xfer(1'b1, 8'h10, hi, v);
            host.xfer(1'b1, 8'h00, {25'h0, pv, cn, sf, op}, v);
            do host.xfer(1'b0, 8'h24, 32'h0, v); while (v[0] !== 1'b0);
            chk(8'h1c, cur);
            chk(8'h20, sav);
            chk(8'h24, {20'h0, 4'(n), 8'h0});
            if (cn && (op < 2 || op[3])) chk(8'h14, p[31:0]);
            if (cn && op[3]) chk(8'h18, p[63:32]);
        end
        tally_and_finish();
    end
endmodule : multiply_psr_transfer_unit_bench
bind mul_psr_unit mul_psr_sva chk (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i,
    .we_i, .stb_i, .cyc_i, .dat_o, .ack_o, .busy_o);
`default_nettype wire
